// ===== core/oies_consts.vh
// Constants for the OTG interrupt enable, status and latch block.
// Assumes inclusion by bare name from the core/ design files.
`ifndef OIES_CONSTS_VH
`define OIES_CONSTS_VH
// ==========================================================
// Register addresses
`define OIES_ADDR_RISE_WR     6'h0D
`define OIES_ADDR_RISE_SET    6'h0E
`define OIES_ADDR_RISE_CLR    6'h0F
`define OIES_ADDR_FALL_WR     6'h10
`define OIES_ADDR_FALL_SET    6'h11
`define OIES_ADDR_FALL_CLR    6'h12
`define OIES_ADDR_STATUS      6'h13
`define OIES_ADDR_LATCH       6'h14
// ==========================================================
// Field positions and reset values
`define OIES_BIT_DETACH       0
`define OIES_BIT_VBUS         1
`define OIES_BIT_SESS         2
`define OIES_BIT_SEND         3
`define OIES_BIT_ID_LINE_GROUNDED        4
`define OIES_NSRC             5
`define OIES_ENABLE_RESET     5'h1F
`define OIES_LATCH_RESET      5'h00
// ==========================================================
// Timing
`define OIES_ID_SETTLE_MS     50
`define OIES_CLK_HZ           100000000
`define OIES_ARM_CYCLES       3'h4
`endif

// ===== core/oies_sync_bit.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes ref_clk and an active-high asynchronous reset.
module oies_sync_bit (
   // Clock and reset
   input  wire ref_clk,
   input  wire rst,
   // Level
   input  wire asyncIn,
   output reg  syncOut
);
   reg stage1;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1  <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// ===== core/oies_event_latch.v
// Interrupt enable, live status and clear-on-read latch registers.
// Assumes register accesses arrive as one-cycle strobes on ref_clk from
// the ULPI register engine; analog sources arrive asynchronously.
`include "oies_consts.vh"
module oies_event_latch #(
   parameter ID_SETTLE_CYCLES = `OIES_ID_SETTLE_MS * (`OIES_CLK_HZ / 1000)
) (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       rst,
   // Register access from the link
   input  wire [5:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWrEn,
   input  wire       regRdEn,
   output reg  [7:0] regRdData,
   output reg        regRdValid,
   // Analog event sources
   input  wire       peripheralDetachFlag,
   input  wire       busVoltageOk,
   input  wire       aDeviceSessionOk,
   input  wire       sessionOver,
   input  wire       idLineGrounded,
   // Mode controls from the OTG and function control logic
   input  wire       idLinePullupEnable,
   input  wire       dplusPulldownEnable,
   input  wire       dminusPulldownEnable,
   input  wire       lowPowerEnter,
   input  wire       serialModeEnter,
   input  wire       clockSuspendControl,
   input  wire       receiveInProgress,
   input  wire       receiveFault,
   // Event outputs
   output wire [4:0] eventPending,
   output wire       eventNotify,
   output wire       receiveReport,
   output wire [4:0] detectPowerOn,
   output reg        idValid
);
   // ==========================================================
   // Source synchronisation
   wire [4:0] rawSrc;
   wire [4:0] syncSrc;
   reg  [4:0] src;
   reg  [4:0] srcPrev;
   reg  [4:0] riseEn;
   reg  [4:0] fallEn;
   reg  [4:0] latch;
   reg  [31:0] idCount;
   reg        lowPower;
   reg  [4:0] next_latch;
   reg  [4:0] setMask;
   wire       hostMode;
   wire       readLatch;
   wire       clearLatch;
   wire [4:0] riseSeen;
   wire [4:0] fallSeen;
   reg  [2:0] armCount;
   wire       armed;
   reg  [7:0] next_rdData;

   // Session-valid source is the A-device session signal itself.
   assign rawSrc = {idLineGrounded, sessionOver, aDeviceSessionOk,
                    busVoltageOk, peripheralDetachFlag};

   genvar g;
   generate
      for (g = 0; g < `OIES_NSRC; g = g + 1) begin : gSync
         oies_sync_bit uSync (
            .ref_clk (ref_clk),
            .rst     (rst),
            .asyncIn (rawSrc[g]),
            .syncOut (syncSrc[g])
         );
      end
   endgenerate

   assign hostMode = dplusPulldownEnable & dminusPulldownEnable;

   // ==========================================================
   // Low-power state
   // Detach status stays masked from low-power entry until the link talks again.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lowPower <= 1'b0;
      end else if (lowPowerEnter) begin
         lowPower <= 1'b1;
      end else if (regWrEn | regRdEn) begin
         lowPower <= 1'b0;
      end
   end

   // Effective source levels; detach masked outside host mode and in low power.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         src      <= 5'h00;
         srcPrev  <= 5'h00;
      end else begin
         src[0]   <= syncSrc[0] & hostMode & ~lowPower & ~lowPowerEnter;
         src[3:1] <= syncSrc[3:1];
         src[4]   <= syncSrc[4] & idLinePullupEnable;
         srcPrev  <= src;
      end
   end

   // ==========================================================
   // Edge arming
   // A source already high at reset release would look like a rising edge
   // while the synchronisers fill, so no event is reported until they have.
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         armCount <= 3'h0;
      else if (!armed)
         armCount <= armCount + 3'h1;
   end

   assign armed = (armCount == `OIES_ARM_CYCLES);

   // ==========================================================
   // ID settle timer: idValid rises only after the pull-up has been on long enough; the ID status and latch bits do not wait for it.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         idCount <= 32'h00000000;
         idValid <= 1'b0;
      end else if (!idLinePullupEnable) begin
         idCount <= 32'h00000000;
         idValid <= 1'b0;
      end else if (idCount < ID_SETTLE_CYCLES) begin
         idCount <= idCount + 32'h00000001;
      end else begin
         idValid <= 1'b1;
      end
   end

   // ==========================================================
   // Enable registers
   // Writes to the status, latch or unmapped addresses fall to the default
   // branch and are dropped, so those registers stay read-only.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         riseEn <= `OIES_ENABLE_RESET;
         fallEn <= `OIES_ENABLE_RESET;
      end else if (regWrEn) begin
         case (regAddr)
            `OIES_ADDR_RISE_WR:  riseEn <= regWrData[4:0];
            `OIES_ADDR_RISE_SET: riseEn <= riseEn | regWrData[4:0];
            `OIES_ADDR_RISE_CLR: riseEn <= riseEn & ~regWrData[4:0];
            `OIES_ADDR_FALL_WR:  fallEn <= regWrData[4:0];
            `OIES_ADDR_FALL_SET: fallEn <= fallEn | regWrData[4:0];
            `OIES_ADDR_FALL_CLR: fallEn <= fallEn & ~regWrData[4:0];
            default: ;
         endcase
      end
   end

   // Detection of a source may be gated off when neither edge is enabled.
   assign detectPowerOn = riseEn | fallEn;

   // ==========================================================
   // Latch
   assign readLatch = regRdEn & (regAddr == `OIES_ADDR_LATCH);

   assign riseSeen   = src & ~srcPrev & riseEn;
   assign fallSeen   = ~src & srcPrev & fallEn;
   assign clearLatch = readLatch | lowPowerEnter | serialModeEnter;

   always @* begin
      setMask = 5'h00;
      if (armed)
         setMask = riseSeen | fallSeen;
      if (clearLatch)
         next_latch = `OIES_LATCH_RESET;
      else
         next_latch = latch | setMask;
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         latch <= `OIES_LATCH_RESET;
      else
         latch <= next_latch;
   end

   // ==========================================================
   // Event outputs
   assign eventPending = setMask;
   assign eventNotify  = |setMask;
   assign receiveReport = receiveInProgress | receiveFault;

   // Serial entry clears the latch whatever the clock-suspend setting, so
   // clockSuspendControl is intentionally left unread here.

   // ==========================================================
   // Read data; a set arriving with a latch read is returned, not stored.
   always @* begin
      next_rdData = regRdData;
      if (regRdEn) begin
         case (regAddr)
            `OIES_ADDR_RISE_WR, `OIES_ADDR_RISE_SET, `OIES_ADDR_RISE_CLR:
               next_rdData = {3'h0, riseEn};
            `OIES_ADDR_FALL_WR, `OIES_ADDR_FALL_SET, `OIES_ADDR_FALL_CLR:
               next_rdData = {3'h0, fallEn};
            `OIES_ADDR_STATUS:   next_rdData = {3'h0, src};
            `OIES_ADDR_LATCH:    next_rdData = {3'h0, latch | setMask};
            default:             next_rdData = 8'h00;
         endcase
      end
   end

   // Read data is held until the next read so a slow link can still pick it up.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdData  <= next_rdData;
         regRdValid <= regRdEn;
      end
   end
endmodule

// ===== dv/oies_link_model.sv
// Link controller model: register reads and writes on the block's access port.
// Assumes the bench calls its tasks; requests change at the falling edge.
module oies_link_model (
   // Clock
   input  wire        ref_clk,
   // Register access
   output logic [5:0] regAddr,
   output logic [7:0] regWrData,
   output logic       regWrEn,
   output logic       regRdEn,
   input  wire  [7:0] regRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Access tasks
   initial {regAddr, regWrData, regWrEn, regRdEn} = 16'h0000;
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge ref_clk) {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
      @(negedge ref_clk) regWrEn = 1'b0;
   endtask
   // Holding the strobe for n cycles gives n back-to-back reads.
   task automatic rd(input logic [5:0] a, input int n, output logic [7:0] v);
      @(negedge ref_clk) {regAddr, regRdEn} = {a, 1'b1};
      repeat (n) @(negedge ref_clk);
      regRdEn = 1'b0;
      v = regRdData;
   endtask
endmodule

// ===== dv/oies_event_latch_sva.sv
// Checker on the ports of the event latch block.
// Assumes the bind below connects it by implicit names.
module oies_event_latch_sva (
   // Clock, reset and access
   input wire       ref_clk,
   input wire       rst,
   input wire [5:0] regAddr,
   input wire       regRdEn,
   input wire [7:0] regRdData,
   input wire       regRdValid,
   // Events and modes
   input wire [4:0] eventPending,
   input wire       eventNotify,
   input wire       receiveReport,
   input wire       receiveInProgress,
   input wire       receiveFault,
   input wire       lowPowerEnter,
   input wire       serialModeEnter
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rdLatch;
      regRdEn && regAddr == 6'h14 && eventPending == 5'h00;
   endsequence
   a_read_answered: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   a_no_stray_valid: assert property (!regRdEn |=> !regRdValid)
      else $error("valid without read");
   a_reserved_zero: assert property (regRdValid |-> regRdData[7:5] == 3'h0)
      else $error("reserved bits set");
   a_rx_unmasked: assert property (
      receiveReport == (receiveInProgress || receiveFault)) else $error("receive report wrong");
   a_notify_any: assert property (eventNotify == (|eventPending))
      else $error("notify mismatch");
   a_read_clears: assert property (s_rdLatch ##1 s_rdLatch |=> regRdData == 8'h00)
      else $error("latch kept after read");
   a_lowpow_clears: assert property (
      lowPowerEnter ##1 !eventNotify ##1 s_rdLatch |=> regRdData == 8'h00)
      else $error("latch kept after low power");
   a_serial_clears: assert property (
      serialModeEnter ##1 !eventNotify ##1 s_rdLatch |=> regRdData == 8'h00)
      else $error("latch kept after serial entry");
   a_set_in_read: assert property (
      regRdEn && regAddr == 6'h14 |=> (regRdData[4:0] & $past(eventPending)) == $past(eventPending))
      else $error("event lost during read");
endmodule
bind oies_event_latch oies_event_latch_sva i_sva (.*);

// ===== dv/tb_otg_interrupt_enable_status_latch.sv
// Bench for the event latch block: register tests through the link model.
// Assumes the checker is bound from its own file.
module tb_otg_interrupt_enable_status_latch;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Signals
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [4:0] src = 5'h00;
   logic       idLinePullupEnable = 1'b0, dplusPulldownEnable = 1'b0;
   logic       dminusPulldownEnable = 1'b0, lowPowerEnter = 1'b0;
   logic       serialModeEnter = 1'b0, receiveInProgress = 1'b0;
   logic       clockSuspendControl = 1'b0, receiveFault = 1'b0;
   logic [5:0] regAddr;
   logic [7:0] regWrData, regRdData, d;
   logic       regWrEn, regRdEn, regRdValid, eventNotify, receiveReport, idValid;
   logic [4:0] eventPending, detectPowerOn;
   wire        peripheralDetachFlag = src[0], busVoltageOk = src[1];
   wire        aDeviceSessionOk = src[2], sessionOver = src[3], idLineGrounded = src[4];
   int         err_count = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   oies_event_latch #(.ID_SETTLE_CYCLES(20)) i_dut (.*);
   oies_link_model i_link (.*);
   // ====================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input int n, input logic [7:0] e);
      i_link.rd(a, n, d);
      chk($sformatf("reg%h", a), e, d);
   endtask
   task automatic pulse(ref logic s);
      @(negedge ref_clk) s = 1'b1;
      @(negedge ref_clk) s = 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ====================
   // Tests
   initial begin
      tick(5);
      rst = 1'b0;
      rchk(6'h10, 1, 8'h1F);
      rchk(6'h0D, 1, 8'h1F);
      rchk(6'h14, 1, 8'h00);
      rchk(6'h20, 1, 8'h00);
      i_link.wr(6'h10, 8'hE5);
      rchk(6'h12, 1, 8'h05);
      i_link.wr(6'h11, 8'h0A);
      rchk(6'h11, 1, 8'h0F);
      i_link.wr(6'h12, 8'h03);
      rchk(6'h10, 1, 8'h0C);
      i_link.wr(6'h0F, 8'h1F);
      rchk(6'h0E, 1, 8'h00);
      chk("detectPowerOn", 8'h0C, {3'h0, detectPowerOn});
      i_link.wr(6'h0D, 8'hFF);
      rchk(6'h0F, 1, 8'h1F);
      i_link.wr(6'h11, 8'h13);
      i_link.wr(6'h13, 8'hFF);
      src = 5'h0E;
      tick(8);
      rchk(6'h13, 1, 8'h0E);
      rchk(6'h14, 1, 8'h0E);
      rchk(6'h14, 2, 8'h00);
      i_link.wr(6'h10, 8'h1D);
      src = 5'h0C;
      tick(8);
      rchk(6'h14, 1, 8'h00);
      src = 5'h08;
      tick(8);
      pulse(lowPowerEnter);
      rchk(6'h14, 1, 8'h00);
      src = 5'h00;
      tick(8);
      pulse(serialModeEnter);
      rchk(6'h14, 1, 8'h00);
      {dplusPulldownEnable, dminusPulldownEnable, src} = 7'h61;
      tick(8);
      rchk(6'h13, 1, 8'h01);
      rchk(6'h14, 1, 8'h01);
      dminusPulldownEnable = 1'b0;
      tick(8);
      rchk(6'h13, 1, 8'h00);
      dminusPulldownEnable = 1'b1;
      pulse(lowPowerEnter);
      rchk(6'h13, 1, 8'h00);
      src = 5'h03;
      rchk(6'h14, 8, 8'h00);
      rchk(6'h14, 1, 8'h00);
      src = 5'h13;
      tick(8);
      rchk(6'h13, 1, 8'h03);
      idLinePullupEnable = 1'b1;
      tick(25);
      chk("idValid", 8'h01, {7'h00, idValid});
      rchk(6'h13, 1, 8'h13);
      receiveFault = 1'b1;
      #1 chk("receiveReport", 8'h01, {7'h00, receiveReport});
      tick(1);
      receiveFault = 1'b0;
      pulse(receiveInProgress);
      test_done();
   end
   initial begin
      #20us;
      err_count++;
      test_done();
   end
endmodule
